// File: design/glitch_filter.sv
// Glitch filter and polarity stage for one hardware trigger line
module glitch_filter
	import trig_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      resetn,
	input  wire logic      line_in,
	input  wire line_cfg_s cfg,
	output logic           level,
	output logic           rise,
	output logic           fall
);

	// ==========================================================
	// Polarity and stability counting
	logic              lvl_q;
	logic              lvl_d;
	logic [FILT_W-1:0] cnt_q;
	logic [FILT_W-1:0] cnt_d;

	wire               raw      = line_in ^ cfg.invert;            // [R6]
	wire               differs  = raw != lvl_q;
	wire [FILT_W-1:0]  need     = raw ? cfg.rise_cycles
	                                  : cfg.fall_cycles;          // [R22]
	// Filtering costs latency of the programmed count per edge
	wire               stable   = !cfg.filter_on || cnt_q >= need; // [R7] [R8]

	assign lvl_d = (differs && stable) ? raw : lvl_q;
	assign cnt_d = !differs ? '0
	             : (stable ? '0 : cnt_q + 1'b1);                 // [R22]

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lvl_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			lvl_q <= lvl_d;
			cnt_q <= cnt_d;
		end
	end

	assign level = lvl_q;
	assign rise  = differs && stable && raw;
	assign fall  = differs && stable && !raw;

endmodule : glitch_filter

// File: design/trig_pkg.sv
// Package: constants and carrier types for the trigger qualification unit
package trig_pkg;

	// ==========================================================
	// Widths and depths
	localparam int unsigned FILT_W      = 16;
	localparam int unsigned DELAY_W     = 24;
	localparam int unsigned QDEPTH      = 8;
	localparam int unsigned QPTR_W      = 3;
	localparam int unsigned QCNT_W      = 4;
	localparam int unsigned BURST_W     = 8;

	// ==========================================================
	// Reset values and burst count minimum
	localparam logic [FILT_W-1:0]  FILT_RST    = 16'h0000;
	localparam logic [DELAY_W-1:0] DELAY_RST   = 24'h000000;
	localparam logic [BURST_W-1:0] BURST_RST   = 8'h01;
	localparam logic [BURST_W-1:0] BURST_MIN   = 8'h01;

	// ==========================================================
	// Frame information tag
	localparam logic [7:0]  CHUNK_ID    = 8'h04;
	localparam logic [7:0]  CHUNK_LEN   = 8'h04;

	// Origin codes, also the tag value
	typedef enum logic [1:0] {
		ORG_SOFTWARE = 2'h0,
		ORG_ISOLATED = 2'h1,
		ORG_BIDIR    = 2'h2,
		ORG_COMBINED = 2'h3
	} origin_e;

	// Bit positions in the allow mask
	localparam int unsigned ALLOW_SW    = 0;
	localparam int unsigned ALLOW_ISO   = 1;
	localparam int unsigned ALLOW_BIDIR = 2;

	// ==========================================================
	// Per-kind trigger configuration
	typedef struct packed {
		logic                 select_on;
		origin_e              origin;
		logic [2:0]           allow;
		logic                 rising;
		logic                 queue_on;
		logic [DELAY_W-1:0]   postpone;
	} trig_cfg_s;

	// Hardware line conditioning
	typedef struct packed {
		logic                 invert;
		logic                 filter_on;
		logic [FILT_W-1:0]    rise_cycles;
		logic [FILT_W-1:0]    fall_cycles;
	} line_cfg_s;

	// Frame tag handed to the frame builder
	typedef struct packed {
		logic [7:0]  chunk_id;
		logic [7:0]  chunk_len;
		logic [31:0] value;
	} frame_tag_s;

endpackage : trig_pkg

// File: design/trigger_source_control.sv
// Trigger qualification, queuing and dispatch for capture sequencing
// How it works
// R1: With triggering off, frames start continuously whenever the sensor is ready.
// R2: Software origin: each software command starts one frame.
// R3: Triggers arriving while the sensor is busy are ignored.
// R4: Programmable postpone between accepted trigger and frame start, default zero.
// R5: Host must set the bidirectional line to input before selecting it.
// R6: Each hardware line may be inverted; default not inverted.
// R7: Optional glitch filter per edge on hardware lines, off by default.
// R8: Filtering adds latency between input edge and qualified trigger.
// R9: Edge choice picks rising or falling edge as the trigger event.
// R10: Combined origin accepts every allowed origin at once.
// R11: Combined with one allowed origin equals selecting it directly.
// R12: Bidirectional line cannot be allowed while it is an output.
// R13: Per-frame and burst triggers each have their own configuration.
// R14: Combined mode tags frames with chunk 4, length 4, origin code.
// R15: Queuing only while capturing in trigger mode; halt clears queues.
// R16: Queue holds up to frame memory depth triggers from the origin.
// R17: Queuing works for any origin including combined mode.
// R18: Per-frame and burst queues are kept separate.
// R19: Burst trigger captures a programmed count of frames, 1 to 255.
// R20: Triggers beyond queue depth are discarded with an overflow event.
// R21: Queued triggers release one at a time on a valid trigger wait.
// R22: Filter needs a stable level for a programmed count per edge.
module trigger_source_control
	import trig_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               capture_go,
	input  wire logic               capture_halt,
	input  wire logic               sensor_ready,
	input  wire logic               isolated_input_line,
	input  wire logic               bidirectional_line,
	input  wire logic               bidir_is_output,
	input  wire line_cfg_s          line_cfg,
	input  wire trig_cfg_s          frame_cfg,
	input  wire trig_cfg_s          burst_cfg,
	input  wire logic [BURST_W-1:0] burst_frames,
	input  wire logic               sw_frame_cmd,
	input  wire logic               sw_burst_cmd,
	output logic                    capturing,
	output logic                    trigger_wait,
	output logic                    frame_start,
	output frame_tag_s              frame_tag,
	output logic                    frame_tag_valid,
	output logic                    overflow_drop_event,
	output logic [QCNT_W-1:0]       frame_queue_level,
	output logic [QCNT_W-1:0]       burst_queue_level
);

	// ==========================================================
	// Line conditioning
	logic iso_rise, iso_fall;
	logic bid_rise, bid_fall;

	glitch_filter u_iso (
		.clk     (clk),
		.resetn  (resetn),
		.line_in (isolated_input_line),
		.cfg     (line_cfg),
		.level   (),
		.rise    (iso_rise),
		.fall    (iso_fall)
	);

	glitch_filter u_bid (
		.clk     (clk),
		.resetn  (resetn),
		.line_in (bidirectional_line),
		.cfg     (line_cfg),
		.level   (),
		.rise    (bid_rise),
		.fall    (bid_fall)
	);

	// ==========================================================
	// Capture session
	logic cap_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cap_q <= 1'b0;
		else if (capture_halt)
			cap_q <= 1'b0;
		else if (capture_go)
			cap_q <= 1'b1;
	end

	assign capturing = cap_q;

	// ==========================================================
	// Origin selection per kind, kept in a generate so both kinds match
	logic [1:0]         hit;      // index 0 per-frame, 1 burst
	origin_e            hit_org  [2];
	logic               start_ok [2];
	logic               q_full   [2];
	logic               q_has    [2];
	origin_e            q_head   [2];
	logic [QCNT_W-1:0]  q_cnt    [2];
	logic               pend     [2];
	origin_e            pend_org [2];
	logic [1:0]         drop;
	trig_cfg_s          kcfg     [2];
	logic               ksw      [2];

	assign kcfg[0] = frame_cfg;
	assign kcfg[1] = burst_cfg;
	assign ksw[0]  = sw_frame_cmd;
	assign ksw[1]  = sw_burst_cmd;

	for (genvar k = 0; k < 2; k++) begin : g_kind                // [R13] [R18]
		wire trig_cfg_s c = kcfg[k];
		wire iso_ev = c.rising ? iso_rise : iso_fall;            // [R9]
		wire bid_ev = (c.rising ? bid_rise : bid_fall)
		              && !bidir_is_output;                      // [R5] [R12]
		wire cmb    = c.origin == ORG_COMBINED;
		// Combined origin with one allow bit collapses to the direct path
		wire use_sw  = cmb ? c.allow[ALLOW_SW]
		                   : c.origin == ORG_SOFTWARE;         // [R10] [R11]
		wire use_iso = cmb ? c.allow[ALLOW_ISO]
		                   : c.origin == ORG_ISOLATED;
		wire use_bid = cmb ? c.allow[ALLOW_BIDIR]
		                   : c.origin == ORG_BIDIR;
		wire sw_hit  = use_sw  && ksw[k];                       // [R2]
		wire iso_hit = use_iso && iso_ev;
		wire bid_hit = use_bid && bid_ev;
		// Simultaneous origins fold into one trigger; lowest code tags it
		assign hit[k] = cap_q && c.select_on
		              && (sw_hit || iso_hit || bid_hit);       // [R10]
		assign hit_org[k] = sw_hit  ? ORG_SOFTWARE
		                  : iso_hit ? ORG_ISOLATED : ORG_BIDIR; // [R14]

		// ------------------------------------------------------
		// Pending queue of origin codes
		origin_e            mem_q [QDEPTH];
		logic [QPTR_W-1:0]  wr_q, rd_q;
		logic [QCNT_W-1:0]  cnt_q;
		wire   q_on   = c.queue_on && c.select_on && cap_q;     // [R15] [R17]
		// Only a trigger the dispatcher takes now bypasses the queue;
		// any other is queued or dropped, never lost without an event
		wire   direct = hit[k] && !pend[k] && cnt_q == '0;
		wire   push   = hit[k] && q_on && !direct
		              && !q_full[k];                             // [R16]
		wire   pop    = !pend[k] && cnt_q != '0;                 // [R21]
		assign drop[k] = hit[k] && !direct
		               && (!q_on || q_full[k]);                  // [R3] [R20]
		assign q_full[k] = cnt_q == QCNT_W'(QDEPTH);
		assign q_has[k]  = cnt_q != '0;
		assign q_head[k] = mem_q[rd_q];
		assign q_cnt[k]  = cnt_q;

		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				wr_q  <= '0;
				rd_q  <= '0;
				cnt_q <= '0;
			end else if (capture_halt || !q_on) begin           // [R15]
				wr_q  <= '0;
				rd_q  <= '0;
				cnt_q <= '0;
			end else begin
				wr_q  <= wr_q + QPTR_W'(push);
				rd_q  <= rd_q + QPTR_W'(pop);
				cnt_q <= cnt_q + QCNT_W'(push) - QCNT_W'(pop);
			end
		end

		always_ff @(posedge clk) begin
			if (push)
				mem_q[wr_q] <= hit_org[k];
		end
	end

	assign frame_queue_level = q_cnt[0];
	assign burst_queue_level = q_cnt[1];

	// ==========================================================
	// Dispatch: burst arms a frame count, per-frame starts frames
	typedef enum logic [1:0] {IDLE, POSTPONE, RUN} disp_e;
	disp_e              st_q, st_d;
	logic [DELAY_W-1:0] dly_q, dly_d;
	logic [BURST_W-1:0] left_q, left_d;
	origin_e            org_q, org_d;
	logic               fs_q, fs_d;
	logic               tv_q;
	logic               ovf_q;

	wire trig_mode = frame_cfg.select_on || burst_cfg.select_on;
	// Sensor ready lags our own frame start by a cycle; fs_q covers it
	wire idle_ok   = cap_q && sensor_ready && st_q == IDLE && !fs_q;
	wire ready     = idle_ok && left_q == '0;
	// Per-frame trigger needs burst arming when both kinds are on; unarmed ones queue or drop
	wire fr_gate   = !burst_cfg.select_on || left_q != '0;
	wire burst_sel = burst_cfg.select_on && !frame_cfg.select_on;
	// Both kinds on: a burst trigger arms only when no count is left
	wire arm_ok    = burst_cfg.select_on && frame_cfg.select_on
	               && cap_q && st_q == IDLE && left_q == '0;
	// Tag every frame start while any kind that is on uses the combined origin
	wire tag_cmb   = (frame_cfg.select_on
	                  && frame_cfg.origin == ORG_COMBINED)
	               || (burst_cfg.select_on
	                  && burst_cfg.origin == ORG_COMBINED);

	// Source of the next accepted trigger, queue head first
	assign start_ok[0] = frame_cfg.select_on && fr_gate
	                   && idle_ok;                                // [R21]
	assign start_ok[1] = burst_sel && ready;
	// A kind is pending while its trigger cannot be taken this cycle
	assign pend[0]     = !start_ok[0];
	assign pend[1]     = !(start_ok[1] || arm_ok);
	assign pend_org[0] = q_has[0] ? q_head[0] : hit_org[0];
	assign pend_org[1] = q_has[1] ? q_head[1] : hit_org[1];

	wire fr_take = start_ok[0] && (q_has[0] || hit[0]);           // [R3]
	wire bu_take = start_ok[1] && (q_has[1] || hit[1]);
	// Burst only arms a counter when per-frame triggers drive frames
	wire bu_arm  = arm_ok && (q_has[1] || hit[1]);               // [R13]
	wire cont_go = idle_ok && !trig_mode;                         // [R1]
	wire [BURST_W-1:0] burst_n = burst_frames < BURST_MIN
	                           ? BURST_MIN : burst_frames;         // [R19]

	assign trigger_wait = idle_ok && trig_mode;

	always_comb begin
		st_d   = st_q;
		dly_d  = dly_q;
		left_d = left_q;
		org_d  = org_q;
		fs_d   = 1'b0;
		unique case (st_q)
			IDLE: begin
				if (cont_go) begin
					fs_d  = 1'b1;
					org_d = ORG_SOFTWARE;
				end else if (fr_take || bu_take) begin
					org_d  = fr_take ? pend_org[0] : pend_org[1];
					dly_d  = fr_take ? frame_cfg.postpone
					                 : burst_cfg.postpone;       // [R4]
					if (bu_take)
						left_d = burst_n - 1'b1;                    // [R19]
					else if (left_q != '0)
						left_d = left_q - 1'b1;
					if ((fr_take ? frame_cfg.postpone
					             : burst_cfg.postpone) == '0) begin
						fs_d = 1'b1;
						st_d = (bu_take && burst_n != BURST_MIN)
						     ? RUN : IDLE;
					end else begin
						st_d = POSTPONE;
					end
				end else if (bu_arm) begin
					left_d = burst_n;
					org_d  = pend_org[1];
				end
			end
			POSTPONE: begin
				dly_d = dly_q - 1'b1;                               // [R4]
				if (dly_q == DELAY_W'(1)) begin
					fs_d = 1'b1;
					st_d = (left_q != '0 && burst_sel) ? RUN : IDLE;
				end
			end
			RUN: begin
				// Burst frames follow back to back as the sensor allows
				if (sensor_ready && !fs_q && left_q != '0) begin
					fs_d   = 1'b1;
					left_d = left_q - 1'b1;
					if (left_q == BURST_MIN)
						st_d = IDLE;
				end
			end
			default: st_d = IDLE;
		endcase
		if (capture_halt || !cap_q) begin                         // [R15]
			st_d   = IDLE;
			left_d = '0;
			fs_d   = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q   <= IDLE;
			dly_q  <= DELAY_RST;
			left_q <= '0;
			org_q  <= ORG_SOFTWARE;
			fs_q   <= 1'b0;
			tv_q   <= 1'b0;
			ovf_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			dly_q  <= dly_d;
			left_q <= left_d;
			org_q  <= org_d;
			fs_q   <= fs_d;
			tv_q   <= fs_d && tag_cmb;                           // [R14]
			ovf_q  <= |drop;                                      // [R20]
		end
	end

	// ==========================================================
	// Outputs
	assign frame_start         = fs_q;
	assign frame_tag_valid     = tv_q;
	assign overflow_drop_event = ovf_q;
	assign frame_tag.chunk_id  = CHUNK_ID;                        // [R14]
	assign frame_tag.chunk_len = CHUNK_LEN;
	assign frame_tag.value     = {30'h0, org_q};

endmodule : trigger_source_control

// File: dv/sensor_model.sv
// Sensor model: busy for a fixed readout time after each frame start
module sensor_model #(
	parameter int BUSY = 12
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic frame_start,
	output logic      sensor_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// Readout time is what caps the frame rate
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cnt <= 0;
		else if (frame_start)
			cnt <= BUSY;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign sensor_ready = (cnt == 0);
endmodule : sensor_model

// File: dv/trigger_source_control_asserts.sv
// Checker: port-level assertions for the trigger qualification unit
module trigger_source_control_asserts
	import trig_pkg::*;
(
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              capture_halt,
	input wire logic              sw_frame_cmd,
	input wire logic              sensor_ready,
	input wire trig_cfg_s         frame_cfg,
	input wire trig_cfg_s         burst_cfg,
	input wire logic              capturing,
	input wire logic              trigger_wait,
	input wire logic              frame_start,
	input wire frame_tag_s        frame_tag,
	input wire logic              frame_tag_valid,
	input wire logic [QCNT_W-1:0] frame_queue_level,
	input wire logic [QCNT_W-1:0] burst_queue_level
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ==========
	// Software command and trigger wait
	sequence sw_idle_cmd;
		capturing && trigger_wait && sw_frame_cmd && !capture_halt &&
		frame_cfg.select_on && frame_cfg.origin == ORG_SOFTWARE &&
		frame_cfg.postpone == '0 && !burst_cfg.select_on;
	endsequence
	chk_sw_start: assert property (sw_idle_cmd |=> frame_start)
		else $error("software command gave no frame");
	chk_wait_cause: assert property (trigger_wait |-> capturing &&
		sensor_ready && (frame_cfg.select_on || burst_cfg.select_on))
		else $error("trigger wait without its cause");
	// ==========
	// Session and queues
	chk_idle_quiet: assert property (!$past(capturing) |-> !frame_start)
		else $error("frame started outside a session");
	chk_halt_clears: assert property (capture_halt |=> !capturing &&
		frame_queue_level == '0 && burst_queue_level == '0)
		else $error("halt left state behind");
	chk_queue_off: assert property (!frame_cfg.queue_on [*2] |->
		frame_queue_level == '0)
		else $error("queue holds entries while off");
	chk_queue_depth: assert property (frame_queue_level <= QDEPTH &&
		burst_queue_level <= QDEPTH)
		else $error("queue above depth");
	chk_one_release: assert property (!$past(capture_halt) &&
		$past(frame_cfg.queue_on) && $past(frame_cfg.select_on) |->
		frame_queue_level + 4'h1 >= $past(frame_queue_level))
		else $error("queue released more than one entry");
	// ==========
	// Frame tag
	chk_tag_frame: assert property (frame_tag_valid |-> frame_start &&
		frame_tag.chunk_id == CHUNK_ID && frame_tag.chunk_len == CHUNK_LEN &&
		frame_tag.value < 32'h3)
		else $error("bad frame tag");
	chk_tag_combined: assert property (frame_start &&
		frame_cfg.select_on && frame_cfg.origin == ORG_COMBINED |->
		frame_tag_valid)
		else $error("combined frame without tag");
endmodule : trigger_source_control_asserts

// File: dv/trigger_source_control_tb.sv
// Testbench: trigger unit driven against a slow sensor model
module trigger_source_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import trig_pkg::*;
	logic clk, resetn, capture_go, capture_halt, sensor_ready;
	logic isolated_input_line, bidirectional_line, bidir_is_output;
	logic sw_frame_cmd, sw_burst_cmd, capturing, trigger_wait, frame_start;
	logic frame_tag_valid, overflow_drop_event;
	line_cfg_s line_cfg;
	trig_cfg_s frame_cfg, burst_cfg;
	frame_tag_s frame_tag;
	logic [BURST_W-1:0] burst_frames;
	logic [QCNT_W-1:0] frame_queue_level, burst_queue_level;
	logic [QCNT_W-1:0] max_q = '0;
	logic [31:0] last_tag = 32'hff;
	int err_count = 0;
	int n_compared = 0;
	int starts = 0;
	int drops = 0;
	int n;
	trigger_source_control uut (.clk, .resetn, .capture_go, .capture_halt,
		.sensor_ready, .isolated_input_line, .bidirectional_line,
		.bidir_is_output, .line_cfg, .frame_cfg, .burst_cfg, .burst_frames,
		.sw_frame_cmd, .sw_burst_cmd, .capturing, .trigger_wait,
		.frame_start, .frame_tag, .frame_tag_valid, .overflow_drop_event,
		.frame_queue_level, .burst_queue_level);
	// Long readout so that triggers pile up behind a frame
	sensor_model #(.BUSY(40)) u_sensor (.clk, .resetn, .frame_start,
		.sensor_ready);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (frame_start === 1'b1)
			starts++;
		if (overflow_drop_event === 1'b1)
			drops++;
		if (frame_tag_valid === 1'b1)
			last_tag = frame_tag.value;
		if (frame_queue_level > max_q)
			max_q = frame_queue_level;
	end
	// ==========
	// Tasks
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic idle(int k);
		repeat (k) @(negedge clk);
	endtask : idle
	task automatic sw(bit burst);
		@(negedge clk);
		sw_frame_cmd = !burst;
		sw_burst_cmd = burst;
		@(negedge clk);
		sw_frame_cmd = 1'b0;
		sw_burst_cmd = 1'b0;
	endtask : sw
	task automatic restart();
		@(negedge clk);
		capture_halt = 1'b1;
		@(negedge clk);
		capture_halt = 1'b0;
		capture_go = 1'b1;
		@(negedge clk);
		capture_go = 1'b0;
		idle(60);
		starts = 0;
		drops = 0;
		max_q = '0;
		last_tag = 32'hff;
	endtask : restart
	// ==========
	// Main sequence
	initial begin
		line_cfg = '0;
		frame_cfg = '0;
		burst_cfg = '0;
		burst_frames = 8'h01;
		capture_go = 1'b0;
		capture_halt = 1'b0;
		isolated_input_line = 1'b0;
		bidirectional_line = 1'b0;
		bidir_is_output = 1'b0;
		sw_frame_cmd = 1'b0;
		sw_burst_cmd = 1'b0;
		resetn = 1'b0;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		frame_cfg.select_on = 1'b1;
		sw(1'b0);
		idle(5);
		check("start before go", 0, starts);
		frame_cfg.select_on = 1'b0;
		restart();
		idle(100);
		check("free run", 1, starts >= 2);
		frame_cfg.select_on = 1'b1;
		restart();
		idle(60);
		check("no free run", 0, starts);
		repeat (3) begin
			sw(1'b0);
			idle(50);
		end
		check("sw starts", 3, starts);
		sw(1'b0);
		sw(1'b0);
		idle(60);
		check("fast cmds", 4, starts);
		check("drop event", 1, drops);
		// Ten commands inside one readout: one starts, eight wait
		frame_cfg.queue_on = 1'b1;
		restart();
		repeat (10) sw(1'b0);
		check("queue full", QDEPTH, max_q);
		idle(1);
		check("overflow", 1, drops);
		for (n = 0; n < 500 && starts < 9; n++)
			idle(1);
		idle(60);
		check("drained", 9, starts);
		if (starts < 9)
			finish_test();
		check("queue empty", 0, frame_queue_level);
		repeat (3) sw(1'b0);
		restart();
		check("halt clears", 0, frame_queue_level);
		frame_cfg.queue_on = 1'b0;
		frame_cfg.postpone = 24'h00000a;
		restart();
		sw(1'b0);
		for (n = 1; n < 50 && starts == 0; n++)
			idle(1);
		check("postpone", 1, n >= 11 && n <= 13);
		frame_cfg.postpone = '0;
		frame_cfg.origin = ORG_ISOLATED;
		line_cfg.filter_on = 1'b1;
		line_cfg.rise_cycles = 16'h0006;
		line_cfg.fall_cycles = 16'h0006;
		// Short glitch then a step, every polarity and edge choice
		for (int k = 0; k < 4; k++) begin
			isolated_input_line = 1'b0;
			line_cfg.invert = k[1];
			frame_cfg.rising = k[0];
			restart();
			isolated_input_line = 1'b1;
			idle(3);
			isolated_input_line = 1'b0;
			idle(20);
			isolated_input_line = 1'b1;
			idle(60);
			check("line edge", k[0] ^ k[1], starts);
		end
		line_cfg.invert = 1'b0;
		frame_cfg.rising = 1'b1;
		frame_cfg.origin = ORG_COMBINED;
		frame_cfg.allow = 3'b110;
		isolated_input_line = 1'b0;
		restart();
		bidirectional_line = 1'b1;
		idle(60);
		check("bidir tag", 2, last_tag);
		isolated_input_line = 1'b1;
		idle(60);
		check("iso tag", 1, last_tag);
		sw(1'b0);
		idle(60);
		check("sw blocked", 2, starts);
		bidir_is_output = 1'b1;
		bidirectional_line = 1'b0;
		idle(20);
		bidirectional_line = 1'b1;
		idle(60);
		check("bidir masked", 2, starts);
		frame_cfg.allow = 3'b001;
		sw(1'b0);
		idle(60);
		check("sw tag", 0, last_tag);
		frame_cfg.select_on = 1'b0;
		burst_cfg.select_on = 1'b1;
		burst_frames = 8'h03;
		restart();
		sw(1'b1);
		idle(200);
		check("burst frames", 3, starts);
		// Both kinds on: burst arms two frames, unarmed frame triggers drop
		frame_cfg.select_on = 1'b1;
		frame_cfg.origin = ORG_SOFTWARE;
		burst_frames = 8'h02;
		restart();
		sw(1'b0);
		sw(1'b1);
		repeat (3) begin
			sw(1'b0);
			idle(50);
		end
		check("armed frames", 2, starts);
		check("unarmed drops", 2, drops);
		finish_test();
	end
endmodule : trigger_source_control_tb

bind trigger_source_control trigger_source_control_asserts u_chk (
	.clk, .resetn, .capture_halt, .sw_frame_cmd, .sensor_ready, .frame_cfg,
	.burst_cfg, .capturing, .trigger_wait, .frame_start, .frame_tag,
	.frame_tag_valid, .frame_queue_level, .burst_queue_level);
